// ===== logic/hcc_coupler.v
// Purpose: coupler control between host word channel and buffer controller
// Assumes: host and buffer controller pins are asynchronous, APB from firmware
// Notes:   one-shot timing rebuilt as counters on clk
`timescale 1ns/1ps
`include "hcc_map.vh"
module hcc_coupler (
    // clock, reset, enable
    input  wire        clk,
    input  wire        resetn,
    input  wire        ce,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // host channel
    input  wire        host_write,
    input  wire        host_read,
    input  wire [3:0]  host_q,
    input  wire [15:0] host_acc,
    input  wire        preset_interrupt,
    output reg  [15:0] host_data_out,
    output reg         host_data_oe,
    output reg         host_reply,
    output reg         host_reject,
    output reg         interrupt_line_out,
    // buffer controller side
    input  wire        ready_busy_line,
    input  wire        data_interrupt_timeout,
    input  wire        power_on_autoload,
    input  wire        parity_error_autoload,
    input  wire        console_clear_autoload,
    output reg         coupler_ready,
    output reg         transfer_terminate,
    output reg         coupler_reply,
    output reg         write_reply_pulse,
    output reg         read_reply_enable,
    output reg         output_strobe_enable,
    output reg         interrupt_status_out,
    // autoload
    output reg         stop_out,
    output reg         channel_clear,
    output reg         master_clear_out,
    output reg         go_pulse,
    output reg         autoload_status_bit,
    output reg         parity_error_clear,
    output reg         fw_pulse_force
);

// ==========================================
// constants
localparam [11:0] MV1_C  = `HCC_MV1_CYC;
localparam [11:0] MV2_C  = `HCC_MV2_CYC;
localparam [11:0] AL1_C  = `HCC_AL1_CYC;
localparam [11:0] AL2_C  = `HCC_AL2_CYC;
localparam [3:0]  HOLD_C = `HCC_HOLD_CYC;
localparam [12:0] LOAD_L = `HCC_LOAD_WORDS - 13'h0001;
localparam [3:0]  HS_IDLE = 4'h1;
localparam [3:0]  HS_MV1  = 4'h2;
localparam [3:0]  HS_MV2  = 4'h4;
localparam [3:0]  HS_HOLD = 4'h8;
localparam [2:0]  AS_IDLE = 3'h1;
localparam [2:0]  AS_T1   = 3'h2;
localparam [2:0]  AS_T2   = 3'h4;

// director 2 through 7
function dir_mid;
    input [3:0] d;
    begin
        dir_mid = (d >= `HCC_DIR_LO) && (d <= `HCC_DIR_HI);
    end
endfunction

// ==========================================
// pin synchronisers
reg  [27:0] s1_reg;
reg  [27:0] s2_reg;
reg  [1:0]  strb_p_reg;
reg  [2:0]  al_p_reg;
wire        h_wr  = s2_reg[27];
wire        h_rd  = s2_reg[26];
wire [3:0]  h_q   = s2_reg[25:22];
wire [15:0] h_acc = s2_reg[21:6];
wire        h_pri = s2_reg[5];
wire        h_rb  = s2_reg[4];
wire        h_tmo = s2_reg[3];
wire [2:0]  h_al  = s2_reg[2:0];
wire        strb_rise = (h_wr | h_rd) & ~(|strb_p_reg);
wire        al_rise   = |(h_al & ~al_p_reg);

// two flops on every host and buffer controller input pin before any logic looks at it
always @(posedge clk) begin
    if (!resetn) begin
        s1_reg     <= 28'h000_0000;
        s2_reg     <= 28'h000_0000;
        strb_p_reg <= 2'h0;
        al_p_reg   <= 3'h0;
    end else if (ce) begin
        s1_reg     <= {host_write, host_read, host_q, host_acc, preset_interrupt,
                       ready_busy_line, data_interrupt_timeout, power_on_autoload,
                       parity_error_autoload, console_clear_autoload};
        s2_reg     <= s1_reg;
        strb_p_reg <= {h_wr, h_rd};
        al_p_reg   <= h_al;
    end
end

// ==========================================
// registers and state
reg  [31:0] ctrl_reg;
reg  [15:0] inw_reg;
reg  [15:0] outw_reg;
reg  [1:0]  fwp_reg;
reg  [3:0]  hs_reg;
reg  [11:0] hcnt_reg;
reg  [3:0]  dir_reg;
reg  [15:0] acc_reg;
reg         wr_reg;
reg         pri_reg;
reg         replied_reg;
reg         bfull_reg;
reg         busy_reg;
reg         inreq_reg;
reg         outreq_reg;
reg         isel_reg;
reg         istage_reg;
reg         term_reg;
reg  [3:0]  tcnt_reg;
reg         crep_reg;
reg         crep_in_reg;
reg  [3:0]  rcnt_reg;
reg  [2:0]  as_reg;
reg  [11:0] acnt_reg;
reg         alflag_reg;
reg  [12:0] wcnt_reg;

// apb decode; pready is already high in the first cycle of the access phase
wire apb_acc = psel & penable & pready;
wire apb_wr  = apb_acc & pwrite;
wire wr_ctrl = apb_wr & (paddr == `HCC_REG_CTRL);
wire wr_outw = apb_wr & (paddr == `HCC_REG_OUTW);
wire fw_mc   = wr_ctrl & pwdata[`HCC_CTL_MC];
wire rdy_ctl = ctrl_reg[`HCC_CTL_READY];
wire eop_rise = ctrl_reg[`HCC_CTL_EOP] & ~fwp_reg[0];
wire pls_rise = ctrl_reg[`HCC_CTL_PLS] & ~fwp_reg[1];

// reply enable for the latched command
wire ren = ((dir_reg == `HCC_DIR_CTRL) & wr_reg)
         | (dir_mid(dir_reg) & rdy_ctl)
         | ((dir_reg == `HCC_DIR_DATA) & ~wr_reg & outreq_reg)
         | ((dir_reg == `HCC_DIR_AL) & wr_reg);
wire mv1_end = hs_reg[1] & (hcnt_reg == MV1_C - 12'h001);
wire mv2_end = hs_reg[2] & (hcnt_reg == MV2_C - 12'h001);
wire acc_ok  = mv1_end & ren;
wire dir1_clr = acc_ok & (dir_reg == `HCC_DIR_CTRL)
              & (acc_reg[`HCC_ACC_CCLR] | acc_reg[`HCC_ACC_ICLR]);
wire xfer     = inreq_reg | outreq_reg;
wire term_go  = ~term_reg & ((xfer & (~h_rb | h_tmo)) | dir1_clr);
wire term_end = term_reg & (tcnt_reg == HOLD_C - 4'h1);
wire wrp_go   = inreq_reg & bfull_reg & host_reply & ~crep_reg;
wire rd_done  = hs_reg[3] & ~h_wr & ~h_rd & replied_reg
              & ~wr_reg & (dir_reg == `HCC_DIR_DATA);
wire crep_end = crep_reg & (rcnt_reg == HOLD_C - 4'h1);
wire eol      = dir1_clr | (alflag_reg & wrp_go & (wcnt_reg == LOAD_L));
wire al_start = al_rise | (acc_ok & (dir_reg == `HCC_DIR_AL));

// ==========================================
// apb slave
always @(posedge clk) begin
    if (!resetn) begin
        pready   <= 1'b0;
        pslverr  <= 1'b0;
        prdata   <= 32'h0000_0000;
        ctrl_reg <= `HCC_CTRL_RST;
        outw_reg <= 16'h0000;
        fwp_reg  <= 2'h0;
    end else if (ce) begin
        pready  <= psel & ~penable & ~pready;
        fwp_reg <= {ctrl_reg[`HCC_CTL_PLS], ctrl_reg[`HCC_CTL_EOP]};
        if (psel & ~penable) begin
            pslverr <= paddr[1:0] != 2'h0 || paddr > `HCC_REG_OUTW;
            case (paddr)
                `HCC_REG_CTRL: prdata <= {27'h0, 1'b0, ctrl_reg[3:0]};
                `HCC_REG_STAT: prdata <= {23'h0, term_reg, coupler_ready,
                                          interrupt_line_out, isel_reg, alflag_reg,
                                          outreq_reg, inreq_reg, busy_reg, bfull_reg};
                `HCC_REG_INW:  prdata <= {16'h0, inw_reg};
                `HCC_REG_OUTW: prdata <= {16'h0, outw_reg};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
        // strobe bits (input request, master clear) do not stick
        if (wr_ctrl) begin
            ctrl_reg <= {28'h0, pwdata[3:2], 1'b0, pwdata[0]};
        end
        if (wr_outw) begin
            outw_reg <= pwdata[15:0];
        end
    end
end

// ==========================================
// host one-shot sequencer
always @(posedge clk) begin
    if (!resetn) begin
        hs_reg        <= HS_IDLE;
        hcnt_reg      <= 12'h000;
        dir_reg       <= 4'h0;
        acc_reg       <= 16'h0000;
        wr_reg        <= 1'b0;
        pri_reg       <= 1'b0;
        replied_reg   <= 1'b0;
        host_reply    <= 1'b0;
        host_reject   <= 1'b0;
        host_data_out <= 16'h0000;
        host_data_oe  <= 1'b0;
        read_reply_enable    <= 1'b0;
        output_strobe_enable <= 1'b0;
        inw_reg       <= 16'h0000;
    end else if (ce) begin
        host_reject <= 1'b0;
        case (hs_reg)
            HS_IDLE: begin
                if (strb_rise) begin
                    dir_reg  <= h_q;
                    acc_reg  <= h_acc;
                    wr_reg   <= h_wr;
                    pri_reg  <= h_pri;
                    hcnt_reg <= 12'h000;
                    hs_reg   <= HS_MV1;
                end
            end
            HS_MV1: begin
                hcnt_reg <= hcnt_reg + 12'h001;
                if (mv1_end) begin
                    hcnt_reg    <= 12'h000;
                    hs_reg      <= HS_MV2;
                    replied_reg <= ren;
                    host_reply  <= ren;
                    host_reject <= ~ren;
                    if (ren & wr_reg) begin
                        inw_reg <= acc_reg;
                    end
                    // output word onto host lines during the window
                    if (ren & ~wr_reg & (dir_reg == `HCC_DIR_DATA)) begin
                        read_reply_enable    <= 1'b1;
                        output_strobe_enable <= 1'b1;
                        host_data_out        <= outw_reg;
                        host_data_oe         <= 1'b1;
                    end
                end
            end
            HS_MV2: begin
                hcnt_reg <= hcnt_reg + 12'h001;
                if (mv2_end) begin
                    hs_reg <= HS_HOLD;
                end
            end
            HS_HOLD: begin
                // reply stands until the host drops its strobe
                if (~h_wr & ~h_rd) begin
                    hs_reg               <= HS_IDLE;
                    host_reply           <= 1'b0;
                    replied_reg          <= 1'b0;
                    read_reply_enable    <= 1'b0;
                    output_strobe_enable <= 1'b0;
                    host_data_oe         <= 1'b0;
                end
            end
            default: begin
                hs_reg <= HS_IDLE;
            end
        endcase
    end
end

// ==========================================
// buffer full, busy, requests
always @(posedge clk) begin
    if (!resetn) begin
        bfull_reg  <= 1'b0;
        busy_reg   <= 1'b0;
        inreq_reg  <= 1'b0;
        outreq_reg <= 1'b0;
    end else if (ce) begin
        // master clear acts like a direct clear on the flop
        if (fw_mc) begin
            bfull_reg <= 1'b0;
        end else if (acc_ok & wr_reg & dir_mid(dir_reg)) begin
            bfull_reg <= 1'b1;
        end else if (wrp_go) begin
            bfull_reg <= 1'b0;
        end
        if (acc_ok & (dir_reg >= `HCC_DIR_LO)) begin
            busy_reg <= 1'b1;
        end else if (fw_mc | (ctrl_reg[`HCC_CTL_EOP] & pls_rise)) begin
            busy_reg <= 1'b0;
        end
        if (wr_ctrl & pwdata[`HCC_CTL_INREQ]) begin
            inreq_reg <= 1'b1;
        end else if (fw_mc | term_end | (crep_end & crep_in_reg)) begin
            inreq_reg <= 1'b0;
        end
        if (wr_outw) begin
            outreq_reg <= 1'b1;
        end else if (fw_mc | term_end | (crep_end & ~crep_in_reg)) begin
            outreq_reg <= 1'b0;
        end
    end
end

// ==========================================
// terminate, ready, coupler reply
always @(posedge clk) begin
    if (!resetn) begin
        term_reg           <= 1'b0;
        tcnt_reg           <= 4'h0;
        transfer_terminate <= 1'b0;
        coupler_ready      <= 1'b0;
        crep_reg           <= 1'b0;
        crep_in_reg        <= 1'b0;
        rcnt_reg           <= 4'h0;
        coupler_reply      <= 1'b0;
        write_reply_pulse  <= 1'b0;
    end else if (ce) begin
        coupler_ready <= h_rb & ~h_tmo;
        if (term_go) begin
            term_reg <= 1'b1;
            tcnt_reg <= 4'h0;
        end else if (term_end) begin
            term_reg <= 1'b0;
        end else if (term_reg) begin
            tcnt_reg <= tcnt_reg + 4'h1;
        end
        transfer_terminate <= term_go | (term_reg & ~term_end);
        write_reply_pulse  <= wrp_go;
        // the reply to the buffer controller lasts a fixed 40 ns
        if (wrp_go | rd_done) begin
            crep_reg    <= 1'b1;
            crep_in_reg <= wrp_go;
            rcnt_reg    <= 4'h0;
        end else if (crep_end) begin
            crep_reg <= 1'b0;
        end else if (crep_reg) begin
            rcnt_reg <= rcnt_reg + 4'h1;
        end
        coupler_reply <= wrp_go | rd_done | (crep_reg & ~crep_end);
    end
end

// ==========================================
// interrupt selection and request
always @(posedge clk) begin
    if (!resetn) begin
        isel_reg             <= 1'b0;
        istage_reg           <= 1'b0;
        interrupt_line_out   <= 1'b0;
        interrupt_status_out <= 1'b0;
    end else if (ce) begin
        if (acc_ok & pri_reg) begin
            isel_reg   <= 1'b0;
            istage_reg <= 1'b0;
        end else if (mv2_end & replied_reg & wr_reg & acc_reg[`HCC_ACC_EOP]
                     & ~interrupt_line_out) begin
            isel_reg <= 1'b1;
        end else if (isel_reg & eop_rise) begin
            istage_reg <= 1'b1;
        end
        // a set on the same edge as a clear wins
        if (istage_reg & pls_rise) begin
            interrupt_line_out   <= 1'b1;
            interrupt_status_out <= 1'b1;
            isel_reg             <= 1'b0;
            istage_reg           <= 1'b0;
        end else if (fw_mc | (acc_ok & (dir_reg == `HCC_DIR_CTRL)
                     & acc_reg[`HCC_ACC_ICLR])) begin
            interrupt_line_out   <= 1'b0;
            interrupt_status_out <= 1'b0;
        end
    end
end

// ==========================================
// autoload sequencer
always @(posedge clk) begin
    if (!resetn) begin
        as_reg              <= AS_IDLE;
        acnt_reg            <= 12'h000;
        alflag_reg          <= 1'b0;
        wcnt_reg            <= 13'h0000;
        stop_out            <= 1'b0;
        channel_clear       <= 1'b0;
        master_clear_out    <= 1'b0;
        go_pulse            <= 1'b0;
        autoload_status_bit <= 1'b0;
        parity_error_clear  <= 1'b0;
        fw_pulse_force      <= 1'b0;
    end else if (ce) begin
        go_pulse <= 1'b0;
        if (al_start) begin
            alflag_reg <= 1'b1;
            wcnt_reg   <= 13'h0000;
        end else if (eol | (wr_outw & pwdata[`HCC_OUT_ALCLR])) begin
            alflag_reg <= 1'b0;
        end else if (alflag_reg & wrp_go) begin
            wcnt_reg <= wcnt_reg + 13'h0001;
        end
        autoload_status_bit <= alflag_reg;
        parity_error_clear  <= alflag_reg;
        fw_pulse_force      <= alflag_reg;
        case (as_reg)
            AS_IDLE: begin
                if (al_start) begin
                    as_reg        <= AS_T1;
                    acnt_reg      <= 12'h000;
                    stop_out      <= 1'b1;
                    channel_clear <= 1'b1;
                end
            end
            AS_T1: begin
                acnt_reg <= acnt_reg + 12'h001;
                if (acnt_reg == AL1_C - 12'h001) begin
                    as_reg           <= AS_T2;
                    acnt_reg         <= 12'h000;
                    master_clear_out <= 1'b1;
                end
            end
            AS_T2: begin
                acnt_reg <= acnt_reg + 12'h001;
                if (acnt_reg == AL2_C - 12'h001) begin
                    as_reg           <= AS_IDLE;
                    master_clear_out <= 1'b0;
                    go_pulse         <= 1'b1;
                    stop_out         <= 1'b0;
                    channel_clear    <= 1'b0;
                end
            end
            default: begin
                as_reg <= AS_IDLE;
            end
        endcase
    end
end

endmodule

// ===== common/hcc_map.vh
// Purpose: constants for the host channel coupler control
// Assumes: 200 MHz clock, APB register access
// Notes:   times in ns; cycle counts are those times at 5 ns a cycle
`ifndef HCC_MAP_VH
`define HCC_MAP_VH
// ==========================================
// timing
`define HCC_CLK_NS     5
`define HCC_MV1_NS     520
`define HCC_MV2_NS     520
`define HCC_HOLD_NS    40
`define HCC_AL1_NS     4000
`define HCC_AL2_NS     4000
`define HCC_MV1_CYC    12'h068
`define HCC_MV2_CYC    12'h068
`define HCC_HOLD_CYC   4'h8
`define HCC_AL1_CYC    12'h320
`define HCC_AL2_CYC    12'h320
`define HCC_LOAD_WORDS 13'h1000
// ==========================================
// director codes and accumulator bits
`define HCC_DIR_DATA   4'h0
`define HCC_DIR_CTRL   4'h1
`define HCC_DIR_LO     4'h2
`define HCC_DIR_HI     4'h7
`define HCC_DIR_AL     4'h9
`define HCC_ACC_CCLR   0
`define HCC_ACC_ICLR   1
`define HCC_ACC_EOP    3
// ==========================================
// register map
`define HCC_REG_CTRL   8'h00
`define HCC_REG_STAT   8'h04
`define HCC_REG_INW    8'h08
`define HCC_REG_OUTW   8'h0c
`define HCC_CTL_READY  0
`define HCC_CTL_INREQ  1
`define HCC_CTL_EOP    2
`define HCC_CTL_PLS    3
`define HCC_CTL_MC     4
`define HCC_OUT_ALCLR  13
`define HCC_CTRL_RST   32'h0000_0000
`endif

// ===== test/hcc_coupler_assertions.sv
// Purpose: concurrent checks on the coupler control pins
// Assumes: ce held high, single clock domain
// Notes:   bound by name to every coupler instance
`timescale 1ns/1ps
module hcc_coupler_chk (
    // clock and reset
    input wire clk, resetn,
    // buffer controller side, plus host data enable and interrupt line
    input wire ready_busy_line, data_interrupt_timeout, power_on_autoload,
    input wire coupler_ready, transfer_terminate, coupler_reply, write_reply_pulse,
    input wire read_reply_enable, output_strobe_enable, host_data_oe,
    input wire interrupt_line_out, interrupt_status_out,
    // autoload
    input wire stop_out, channel_clear, master_clear_out, go_pulse,
    input wire autoload_status_bit, parity_error_clear, fw_pulse_force
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ==========================================
    // helper: cycles spent in the master clear period
    int mc_cnt;
    always @(posedge clk) begin
        if (!resetn || !master_clear_out) mc_cnt <= 0;
        else mc_cnt <= mc_cnt + 1;
    end
    // ==========================================
    // checks
    a_term_width: assert property ($rose(transfer_terminate) |=> transfer_terminate[*7] ##1 !transfer_terminate)
        else $error("terminate width wrong");
    a_reply_width: assert property ($rose(coupler_reply) |=> coupler_reply[*7] ##1 !coupler_reply)
        else $error("coupler reply width wrong");
    a_wrp_reply: assert property (write_reply_pulse |=> !write_reply_pulse ##[0:4] coupler_reply)
        else $error("write reply pulse not followed by reply");
    a_ready_on: assert property ((ready_busy_line && !data_interrupt_timeout)[*5] |-> coupler_ready)
        else $error("coupler ready missing");
    a_ready_off: assert property ((!ready_busy_line || data_interrupt_timeout)[*5] |-> !coupler_ready)
        else $error("coupler ready without cause");
    a_strobe_with: assert property (read_reply_enable |-> output_strobe_enable && host_data_oe)
        else $error("read reply without data strobe");
    a_irq_status: assert property (interrupt_line_out == interrupt_status_out)
        else $error("interrupt status differs");
    a_al_start: assert property ($rose(power_on_autoload) |-> ##[1:8] stop_out && channel_clear)
        else $error("autoload did not start");
    a_al_forces: assert property (autoload_status_bit == parity_error_clear && fw_pulse_force == parity_error_clear)
        else $error("autoload forced signals differ");
    a_mc_stops: assert property (master_clear_out |-> stop_out && channel_clear)
        else $error("master clear outside stop period");
    a_mc_length: assert property ($fell(master_clear_out) |-> mc_cnt inside {[799:801]})
        else $error("master clear period length wrong");
    a_go_after: assert property ($rose(go_pulse) |-> $past(master_clear_out) || $past(master_clear_out, 2))
        else $error("go without master clear release");
    // main scenarios reached
    c_go: cover property ($rose(go_pulse));
    c_wrp: cover property (write_reply_pulse);
    c_term: cover property ($rose(transfer_terminate));
    c_out: cover property (read_reply_enable ##[1:40] coupler_reply);
endmodule
bind hcc_coupler hcc_coupler_chk u_chk (.*);

// ===== test/hcc_host_model.sv
// Purpose: host channel side, one word strobe per call
// Assumes: strobes are levels, reply or reject closes a word
// Notes:   released q and acc lines show the inverse of the last value
`timescale 1ns/1ps
module hcc_host_model (
    // reply from the coupler
    input wire clk, host_reply, host_reject,
    input wire [15:0] host_data_out,
    // strobes and lines to the coupler
    output logic host_write, host_read, preset_interrupt,
    output logic [3:0] host_q,
    output logic [15:0] host_acc
);
    initial begin
        host_write = 0;
        host_read = 0;
        preset_interrupt = 0;
        host_q = 4'hf;
        host_acc = 16'h0000;
    end
    // strobe held until answered; lag makes a slow host
    task automatic xfer(input bit rdn, input [3:0] q, input [15:0] acc, input int lag,
                        output bit ok, output logic [15:0] dat, output bit hung);
        int i;
        @(posedge clk);
        host_q <= q;
        host_acc <= acc;
        if (rdn) host_read <= 1'b1;
        else host_write <= 1'b1;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            if (host_reply === 1'b1 || host_reject === 1'b1) break;
        end
        hung = (i == 400);
        ok = (host_reply === 1'b1);
        dat = host_data_out;
        repeat (lag) @(posedge clk);
        host_write <= 1'b0;
        host_read <= 1'b0;
        host_q <= ~q;
        host_acc <= ~acc;
        // the second window runs on after a reject too, so wait it out
        for (i = 0; i < 200 && host_reply === 1'b1; i++) @(posedge clk);
        hung = hung | (i == 200);
        repeat (120) @(posedge clk);
    endtask
endmodule

// ===== test/tb_hcc_coupler.sv
// Purpose: self-checking bench for the coupler control
// Assumes: apb firmware side driven here, host side by the model
// Notes:   each scenario is one task that judges its own results
`timescale 1ns/1ps
`include "hcc_map.vh"
`define CHK(n_, e_, g_) begin comparisons++; if ((g_) !== (e_)) begin n_fail++; \
    $display("unexpected %s exp %0h got %0h", n_, e_, g_); end end
module tb_hcc_coupler;
    logic clk = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ready_busy_line = 1, data_interrupt_timeout = 0, power_on_autoload = 0;
    logic parity_error_autoload = 0, console_clear_autoload = 0;
    wire [31:0] prdata;
    wire [15:0] host_acc, host_data_out;
    wire [3:0] host_q;
    wire pready, pslverr, host_write, host_read, preset_interrupt, host_data_oe, host_reply, host_reject;
    wire interrupt_line_out, coupler_ready, transfer_terminate, coupler_reply, write_reply_pulse;
    wire read_reply_enable, output_strobe_enable, interrupt_status_out, stop_out, channel_clear;
    wire master_clear_out, go_pulse, autoload_status_bit, parity_error_clear, fw_pulse_force;
    int n_fail = 0, comparisons = 0, n_wrp, n_term, n_go, n_crep, lag = 0;
    logic [15:0] hdat;
    logic serr;
    hcc_coupler uut (.*);
    hcc_host_model u_host (.clk(clk), .host_reply(host_reply), .host_reject(host_reject),
        .host_data_out(host_data_out), .host_write(host_write), .host_read(host_read),
        .preset_interrupt(preset_interrupt), .host_q(host_q), .host_acc(host_acc));
    always #2.5 clk = ~clk;
    // pulse and level counters, since pulses last one cycle
    always @(posedge clk) begin
        n_wrp += write_reply_pulse;
        n_term += transfer_terminate;
        n_go += go_pulse;
        n_crep += coupler_reply;
    end
    // ==========================================
    // bus and host helpers
    task stop_test;
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input bit w, input [7:0] a, input [31:0] d, output logic [31:0] r);
        int i;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        serr = pslverr;
        psel <= 0;
        penable <= 0;
        if (i == 20) begin n_fail++; stop_test; end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        logic [31:0] r;
        apb(1, a, d, r);
    endtask
    task automatic st(input [7:0] a, input [31:0] m, e, input string nm);
        logic [31:0] r;
        apb(0, a, 32'h0, r);
        `CHK(nm, e, r & m)
    endtask
    task automatic host(input bit rdn, input [3:0] q, input [15:0] acc, input bit ok);
        bit got, hung;
        u_host.xfer(rdn, q, acc, lag, got, hdat, hung);
        if (hung) begin n_fail++; stop_test; end
        `CHK("host reply", ok, got)
    endtask
    // ==========================================
    // scenarios
    task t_input;
        wr(`HCC_REG_CTRL, 32'h1);
        host(0, `HCC_DIR_LO, 16'h1234, 1);
        st(`HCC_REG_STAT, 32'h3, 32'h3, "full busy");
        st(`HCC_REG_INW, 32'hffff, 32'h1234, "in word");
        wr(`HCC_REG_CTRL, 32'h11);
        st(`HCC_REG_STAT, 32'h3, 32'h0, "full clr");
        n_wrp = 0;
        wr(`HCC_REG_CTRL, 32'h3);
        host(0, `HCC_DIR_HI, 16'h5a5a, 1);
        `CHK("wr pulse", 1, n_wrp)
        st(`HCC_REG_STAT, 32'h5, 32'h0, "full inreq");
        host(0, 4'h8, 16'h0000, 0);
        wr(`HCC_REG_CTRL, 32'h0);
        host(0, `HCC_DIR_LO, 16'h0000, 0);
        st(`HCC_REG_STAT, 32'h1, 32'h0, "no full");
        st(8'h10, 32'hffffffff, 32'h0, "unmapped");
        `CHK("slverr", 1'b1, serr)
        $display("test input done");
    endtask
    task t_irq;
        host(0, `HCC_DIR_CTRL, 16'h0008, 1);
        st(`HCC_REG_STAT, 32'h60, 32'h20, "armed");
        wr(`HCC_REG_CTRL, 32'h4);
        wr(`HCC_REG_CTRL, 32'hc);
        repeat (2) @(posedge clk); // pulse rise is seen an edge after the write
        `CHK("irq", 1'b1, interrupt_line_out)
        st(`HCC_REG_STAT, 32'h42, 32'h40, "irq idle");
        n_term = 0;
        host(0, `HCC_DIR_CTRL, 16'h0002, 1);
        `CHK("irq clr", 1'b0, interrupt_line_out)
        `CHK("term len", 8, n_term)
        wr(`HCC_REG_CTRL, 32'h0);
        $display("test interrupt done");
    endtask
    task t_output;
        wr(`HCC_REG_OUTW, 32'h00a5);
        n_crep = 0;
        lag = 25;
        host(1, `HCC_DIR_DATA, 16'h0000, 1);
        lag = 0;
        `CHK("out data", 16'h00a5, hdat)
        `CHK("oe off", 1'b0, host_data_oe)
        `CHK("reply len", 8, n_crep)
        st(`HCC_REG_STAT, 32'h8, 32'h0, "out req");
        $display("test output done");
    endtask
    task t_term;
        `CHK("ready", 1'b1, coupler_ready)
        wr(`HCC_REG_OUTW, 32'h0001);
        n_term = 0;
        @(posedge clk) ready_busy_line <= 0;
        repeat (20) @(posedge clk);
        `CHK("ready lost", 1'b0, coupler_ready)
        `CHK("term len", 8, n_term)
        st(`HCC_REG_STAT, 32'h8, 32'h0, "req reset");
        @(posedge clk) ready_busy_line <= 1;
        data_interrupt_timeout <= 1;
        repeat (8) @(posedge clk);
        `CHK("timeout", 1'b0, coupler_ready)
        @(posedge clk) data_interrupt_timeout <= 0;
        $display("test terminate done");
    endtask
    task t_auto;
        int i;
        n_go = 0;
        @(posedge clk) power_on_autoload <= 1;
        repeat (10) @(posedge clk);
        power_on_autoload <= 0;
        `CHK("stop", 1'b1, stop_out)
        for (i = 0; i < 2000 && n_go == 0; i++) @(posedge clk);
        `CHK("go", 1, n_go)
        if (n_go == 0) stop_test;
        `CHK("mc off", 1'b0, master_clear_out)
        st(`HCC_REG_STAT, 32'h10, 32'h10, "al flag");
        wr(`HCC_REG_OUTW, 32'h2000);
        st(`HCC_REG_STAT, 32'h10, 32'h0, "al clr");
        host(0, `HCC_DIR_AL, 16'h0000, 1);
        `CHK("stop dir", 1'b1, stop_out)
        host(0, `HCC_DIR_CTRL, 16'h0001, 1);
        st(`HCC_REG_STAT, 32'h10, 32'h0, "al end");
        $display("test autoload done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1;
        repeat (3) @(posedge clk);
        t_input;
        t_irq;
        t_output;
        t_term;
        t_auto;
        stop_test;
    end
endmodule
